// ---- hdl/lfc_pkg.sv ----
package lfc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_THR_MAIN = 8'h04;
  localparam logic [7:0] OFS_THR_BKP = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  // field positions
  localparam int CTRL_FC_ON_BIT = 0;
  localparam int ST_HALT_BIT = 0;
  localparam int ST_REG_BRK_BIT = 1;
  localparam int ST_PRI_BRK_BIT = 2;
  localparam int ST_BKP_BRK_BIT = 3;
  localparam int ST_TIMER_LSB = 16;
  localparam int IRQ_PAUSE_SENT = 0;
  localparam int IRQ_BKP_SENT = 1;
  localparam int IRQ_PAUSE_RCVD = 2;
  localparam int IRQ_OVFL = 3;
  localparam int IRQ_W = 4;
  // reset values
  localparam logic CTRL_FC_ON_RST = 1'b1;
  localparam int THR_MAIN_RST = 'hc0;
  localparam int THR_BKP_RST = 'he0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
  // timing
  localparam int PAUSE_UNIT_CYC = 2;
  localparam int PAUSE_UNITS_MIN = 1;
  localparam int PAUSE_UNITS_DEF = 255;
  localparam int RENEW_LEAD_DEF = 8;
  localparam int TIMER_W = 16;
  typedef enum {TRIG_REG, TRIG_PRI, TRIG_BOTH} lfc_trig_t;
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } lfc_ahb_req_t;
endpackage

// ---- hdl/lfc_pause_ctrl.sv ----
// Overview of operation
// RULE1: enabled trigger port fill crossing threshold sends a pause instruction.
// RULE2: received pause halts transmit for configured duration, then resumes.
// RULE3: breach near pause expiry sends renewal early, leaving no gap.
// RULE4: pause halts regular and priority transmit ports alike.
// RULE5: without flow control, any receive overflow raises link error and restart.
// RULE6: backup option adds a second, higher threshold; absent by default.
// RULE7: crossing the backup threshold sends a second pause instruction; none is sent when main_send fires in the same cycle.
// RULE8: flow control is a build option, absent by default.
// RULE9: regular-port mode triggers on regular fifo only; forced if no priority port.
// RULE10: priority-port mode triggers on priority fifo only; forced if no regular.
// RULE11: both-ports mode triggers on either fifo; default when both built.
// RULE12: pause counted in two-cycle units, 1 to 255, default 255.
// RULE13: breached while fill at or above threshold, cleared below it.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register addresses.
module lfc_pause_ctrl #(
  parameter bit FC_EN = 1'b0,
  parameter bit BACKUP_EN = 1'b0,
  parameter bit REG_PORT_EN = 1'b1,
  parameter bit PRI_PORT_EN = 1'b1,
  parameter lfc_pkg::lfc_trig_t TRIG_MODE = lfc_pkg::TRIG_BOTH,
  parameter int PAUSE_UNITS = lfc_pkg::PAUSE_UNITS_DEF,
  parameter int RENEW_LEAD = lfc_pkg::RENEW_LEAD_DEF,
  parameter int LEVEL_W = 8
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  input wire lfc_pkg::lfc_ahb_req_t I_AHB,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  input wire logic [LEVEL_W-1:0] I_REG_FILL,
  input wire logic [LEVEL_W-1:0] I_PRI_FILL,
  input wire logic I_REG_OVFL,
  input wire logic I_PRI_OVFL,
  input wire logic I_PAUSE_RCVD,
  output logic O_PAUSE_REQ,
  output logic O_REG_TX_HALT,
  output logic O_PRI_TX_HALT,
  output logic O_LINK_RESTART,
  output logic O_IRQ
);
  import lfc_pkg::*;

  // ****************************************
  // build-time settings
  // ****************************************
  localparam lfc_trig_t EFF_MODE = !PRI_PORT_EN ? TRIG_REG :
    (!REG_PORT_EN ? TRIG_PRI : TRIG_BOTH == TRIG_MODE ? TRIG_BOTH : TRIG_MODE);
  localparam int PAUSE_CYC = PAUSE_UNITS * PAUSE_UNIT_CYC;
  localparam int LEAD_CYC = RENEW_LEAD < PAUSE_CYC ? RENEW_LEAD : PAUSE_CYC - 1;
  localparam logic [TIMER_W-1:0] PAUSE_CYC_T = TIMER_W'(PAUSE_CYC);
  localparam logic [TIMER_W-1:0] LEAD_CYC_T = TIMER_W'(LEAD_CYC);
  localparam logic [7:0] PAUSE_UNITS_T = 8'(PAUSE_UNITS);

  // ****************************************
  // bus slave
  // ****************************************
  logic acc;
  logic wr_q;
  logic [7:0] addr_q;
  logic [31:0] rd_data;
  logic ctrl_fc_on;
  logic [LEVEL_W-1:0] thr_main;
  logic [LEVEL_W-1:0] thr_bkp;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] ev;
  logic rd_clr;
  logic [TIMER_W-1:0] rx_timer;
  logic [7:0] tx_units;
  logic tx_div;
  logic reg_brk;
  logic pri_brk;
  logic bkp_brk;
  logic bkp_q;
  logic trig;
  logic fc_on;
  logic main_send;
  logic bkp_send;
  logic halt;

  assign acc = I_AHB.hsel && I_AHB.htrans[1] && I_AHB.hready;
  assign rd_clr = acc && !I_AHB.hwrite && I_AHB.haddr[7:0] == OFS_IRQ_STAT;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end
    else
    begin
      wr_q <= acc && I_AHB.hwrite;
      addr_q <= I_AHB.haddr[7:0];
    end
  end

  always_comb
  begin
    rd_data = 32'h0;
    if (I_AHB.haddr[31:8] == 24'h0)
    begin
      unique case (I_AHB.haddr[7:0])
        OFS_CTRL: rd_data[CTRL_FC_ON_BIT] = ctrl_fc_on;
        OFS_THR_MAIN: rd_data[LEVEL_W-1:0] = thr_main;
        OFS_THR_BKP: rd_data[LEVEL_W-1:0] = thr_bkp;
        OFS_STATE:
        begin
          rd_data[ST_HALT_BIT] = halt;
          rd_data[ST_REG_BRK_BIT] = reg_brk;
          rd_data[ST_PRI_BRK_BIT] = pri_brk;
          rd_data[ST_BKP_BRK_BIT] = bkp_brk;
          rd_data[ST_TIMER_LSB +: TIMER_W] = rx_timer;
        end
        OFS_IRQ_STAT: rd_data[IRQ_W-1:0] = irq_stat;
        OFS_IRQ_MASK: rd_data[IRQ_W-1:0] = irq_mask;
        default: rd_data = 32'h0;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
      O_HRDATA <= 32'h0;
    else if (acc && !I_AHB.hwrite)
      O_HRDATA <= rd_data;
  end

  // writes to unmapped offsets are dropped; haddr[31:8] is not decoded for writes
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      ctrl_fc_on <= CTRL_FC_ON_RST;
      thr_main <= LEVEL_W'(THR_MAIN_RST);
      thr_bkp <= LEVEL_W'(THR_BKP_RST);
      irq_mask <= IRQ_MASK_RST;
    end
    else if (wr_q)
    begin
      unique case (addr_q)
        OFS_CTRL: ctrl_fc_on <= I_AHB.hwdata[CTRL_FC_ON_BIT];
        OFS_THR_MAIN: thr_main <= I_AHB.hwdata[LEVEL_W-1:0];
        OFS_THR_BKP: thr_bkp <= I_AHB.hwdata[LEVEL_W-1:0];
        OFS_IRQ_MASK: irq_mask <= I_AHB.hwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  assign ev[IRQ_PAUSE_SENT] = main_send;
  assign ev[IRQ_BKP_SENT] = bkp_send;
  assign ev[IRQ_PAUSE_RCVD] = FC_EN && I_PAUSE_RCVD;
  assign ev[IRQ_OVFL] = I_REG_OVFL || I_PRI_OVFL;

  // new events win over a clearing read
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
      irq_stat <= '0;
    else
      irq_stat <= (rd_clr ? '0 : irq_stat) | ev;
  end

  assign O_IRQ = |(irq_stat & irq_mask);

  // ****************************************
  // receive side: breach and pause send
  // ****************************************
  assign fc_on = FC_EN && ctrl_fc_on; // RULE8
  assign reg_brk = REG_PORT_EN && EFF_MODE != TRIG_PRI && I_REG_FILL >= thr_main; // RULE9 RULE13
  assign pri_brk = PRI_PORT_EN && EFF_MODE != TRIG_REG && I_PRI_FILL >= thr_main; // RULE10 RULE13
  assign trig = fc_on && (reg_brk || pri_brk); // RULE11
  assign bkp_brk = fc_on && BACKUP_EN && ((EFF_MODE != TRIG_PRI && I_REG_FILL >= thr_bkp) ||
    (EFF_MODE != TRIG_REG && I_PRI_FILL >= thr_bkp)); // RULE6
  assign main_send = trig && rx_timer <= LEAD_CYC_T; // RULE1 RULE3
  assign bkp_send = bkp_brk && !bkp_q && !main_send; // RULE7

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
      bkp_q <= 1'b0;
    else
      bkp_q <= bkp_brk;
  end

  // shadow of the far pause, renewed before it runs out
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
      rx_timer <= '0;
    else if (main_send || bkp_send)
      rx_timer <= PAUSE_CYC_T; // RULE3
    else if (rx_timer != '0)
      rx_timer <= rx_timer - TIMER_W'(1);
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
      O_PAUSE_REQ <= 1'b0;
    else
      O_PAUSE_REQ <= main_send || bkp_send; // RULE1 RULE7
  end

  // ****************************************
  // transmit side: pause timer
  // ****************************************
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      tx_units <= 8'h00;
      tx_div <= 1'b0;
    end
    else if (FC_EN && I_PAUSE_RCVD)
    begin
      tx_units <= PAUSE_UNITS_T; // RULE2 RULE12
      tx_div <= 1'b0;
    end
    else if (tx_units != 8'h00)
    begin
      tx_div <= !tx_div;
      if (tx_div)
        tx_units <= tx_units - 8'h01; // RULE12
    end
  end

  assign halt = tx_units != 8'h00; // RULE2
  assign O_REG_TX_HALT = halt; // RULE4
  assign O_PRI_TX_HALT = halt; // RULE4

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
      O_LINK_RESTART <= 1'b0;
    else
      O_LINK_RESTART <= !FC_EN && (I_REG_OVFL || I_PRI_OVFL); // RULE5
  end

  // ****************************************
  // checks
  // ****************************************
  logic [TIMER_W-1:0] since_rcv;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
      since_rcv <= '0;
    else if (FC_EN && I_PAUSE_RCVD)
      since_rcv <= 16'h0001;
    else if (since_rcv != 16'hffff)
      since_rcv <= since_rcv + 16'h0001;
  end

  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RST_B);

  chk_pause_first_send: assert property ( // RULE1
    trig && rx_timer == '0 |=> O_PAUSE_REQ && rx_timer == PAUSE_CYC_T)
    else $error("breach did not send a pause");
  chk_halt_span: assert property ( // RULE2
    $fell(halt) |-> since_rcv == TIMER_W'(PAUSE_CYC + 1))
    else $error("pause length wrong");
  chk_renew_no_gap: assert property ( // RULE3
    trig |=> rx_timer != '0)
    else $error("pause shadow lapsed during breach");
  chk_both_ports_halt: assert property ( // RULE4
    (O_REG_TX_HALT == O_PRI_TX_HALT) and
    (FC_EN && I_PAUSE_RCVD |=> (O_REG_TX_HALT && O_PRI_TX_HALT)[*2]))
    else $error("ports not halted together");
  chk_ovfl_restart: assert property ( // RULE5
    !FC_EN && (I_REG_OVFL || I_PRI_OVFL) |=> O_LINK_RESTART && irq_stat[IRQ_OVFL])
    else $error("overflow did not restart link");
  chk_backup_send: assert property ( // RULE7
    $rose(bkp_brk) && !main_send |=> O_PAUSE_REQ && irq_stat[IRQ_BKP_SENT])
    else $error("backup pause missing");
  chk_no_backup: assert property ( // RULE6
    !BACKUP_EN |-> !bkp_brk && !irq_stat[IRQ_BKP_SENT])
    else $error("backup acted while absent");
  chk_fc_absent_idle: assert property ( // RULE8
    !FC_EN |-> !O_PAUSE_REQ && !halt && rx_timer == '0)
    else $error("pause logic active without flow control");
  chk_trig_cause: assert property ( // RULE11
    O_PAUSE_REQ |-> $past(trig) || $past(bkp_brk))
    else $error("pause without a breach");
  chk_reg_mode_only: assert property ( // RULE9
    EFF_MODE == TRIG_REG |-> !pri_brk)
    else $error("priority fifo triggered in regular mode");
  chk_pri_mode_only: assert property ( // RULE10
    EFF_MODE == TRIG_PRI |-> !reg_brk)
    else $error("regular fifo triggered in priority mode");
  chk_breach_level: assert property ( // RULE13
    fc_on && REG_PORT_EN && EFF_MODE != TRIG_PRI && I_REG_FILL < thr_main |-> !reg_brk)
    else $error("breach below threshold");
endmodule

// ---- tb/lfc_peer_model.sv ----
// ****
// far endpoint: halts its transmit on each pause
// ****
module lfc_peer_model #(
  parameter int PAUSE_CYC = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_pause_req,
  input wire logic i_send,
  input wire logic i_watch,
  output logic o_pause_rcvd,
  output int o_req_cnt,
  output int o_gap_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  int halt;
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      halt <= 0;
      o_req_cnt <= 0;
      o_gap_cnt <= 0;
      o_pause_rcvd <= 1'h0;
    end
    else
    begin
      o_pause_rcvd <= i_send;
      if (i_pause_req)
      begin
        halt <= PAUSE_CYC;
        o_req_cnt <= o_req_cnt + 1;
      end
      else if (halt > 0)
        halt <= halt - 1;
      if (i_watch && halt == 0 && !i_pause_req)
        o_gap_cnt <= o_gap_cnt + 1;
    end
  end
endmodule

// ---- tb/link_flow_control_pause_tb.sv ----
module link_flow_control_pause_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lfc_pkg::*;
  localparam int PU = 8;
  localparam int PC = PU * PAUSE_UNIT_CYC;
  logic I_CLK_SYS = 1'h0;
  logic I_RST_B = 1'h0;
  lfc_ahb_req_t ahb = '0;
  lfc_ahb_req_t ahb_w;
  logic [31:0] O_HRDATA;
  logic O_HREADYOUT, O_HRESP, O_PAUSE_REQ, O_REG_TX_HALT, O_PRI_TX_HALT, O_LINK_RESTART, O_IRQ;
  logic [7:0] reg_fill = 8'h0, pri_fill = 8'h0;
  logic reg_ovfl = 1'h0, pri_ovfl = 1'h0, send = 1'h0, watch = 1'h0, restart_seen = 1'h0;
  logic pause_rcvd;
  logic nofc_req, nofc_halt, nofc_restart;
  logic nofc_act = 1'h0;
  int nofc_rst_cnt = 0;
  logic [31:0] rd, thr, bkp;
  int err_total = 0, compares = 0, seed = 94176, n0, hi, diff, req_cnt, gap_cnt;
  always_comb
  begin
    ahb_w = ahb;
    ahb_w.hready = O_HREADYOUT;
  end
  initial
  begin
    forever #50 I_CLK_SYS = ~I_CLK_SYS;
  end
  always @(posedge I_CLK_SYS)
    if (O_LINK_RESTART === 1'h1)
      restart_seen <= 1'h1;
  // second endpoint built without flow control
  always @(posedge I_CLK_SYS)
  begin
    if (nofc_restart === 1'h1)
      nofc_rst_cnt <= nofc_rst_cnt + 1;
    if (nofc_req !== 1'h0 || nofc_halt !== 1'h0)
      nofc_act <= 1'h1;
  end
  lfc_pause_ctrl #(.FC_EN(1'b1), .BACKUP_EN(1'b1), .PAUSE_UNITS(PU)) uut (
    .I_CLK_SYS(I_CLK_SYS), .I_RST_B(I_RST_B), .I_AHB(ahb_w), .O_HRDATA(O_HRDATA),
    .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .I_REG_FILL(reg_fill),
    .I_PRI_FILL(pri_fill), .I_REG_OVFL(reg_ovfl), .I_PRI_OVFL(pri_ovfl),
    .I_PAUSE_RCVD(pause_rcvd), .O_PAUSE_REQ(O_PAUSE_REQ), .O_REG_TX_HALT(O_REG_TX_HALT),
    .O_PRI_TX_HALT(O_PRI_TX_HALT), .O_LINK_RESTART(O_LINK_RESTART), .O_IRQ(O_IRQ));
  lfc_peer_model #(.PAUSE_CYC(PC)) peer (
    .i_clk(I_CLK_SYS), .i_rst_b(I_RST_B), .i_pause_req(O_PAUSE_REQ), .i_send(send),
    .i_watch(watch), .o_pause_rcvd(pause_rcvd), .o_req_cnt(req_cnt), .o_gap_cnt(gap_cnt));
  lfc_pause_ctrl #(.PAUSE_UNITS(PU)) uut_nofc (
    .I_CLK_SYS(I_CLK_SYS), .I_RST_B(I_RST_B), .I_AHB(ahb_w), .O_HRDATA(),
    .O_HREADYOUT(), .O_HRESP(), .I_REG_FILL(reg_fill),
    .I_PRI_FILL(pri_fill), .I_REG_OVFL(reg_ovfl), .I_PRI_OVFL(pri_ovfl),
    .I_PAUSE_RCVD(pause_rcvd), .O_PAUSE_REQ(nofc_req), .O_REG_TX_HALT(nofc_halt),
    .O_PRI_TX_HALT(), .O_LINK_RESTART(nofc_restart), .O_IRQ());
  // ****
  // shared tasks
  // ****
  task automatic end_of_test;
    $display("counts: compares=%0d errors=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge I_CLK_SYS);
  endtask
  task automatic rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge I_CLK_SYS);
      n++;
    end
    while (O_HREADYOUT !== 1'h1 && n < 64);
    if (n >= 64)
    begin
      err_total++;
      end_of_test;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    ahb.hsel <= 1'h1;
    ahb.htrans <= 2'h2;
    ahb.haddr <= {24'h0, a};
    ahb.hwrite <= w;
    ahb.hsize <= 3'h2;
    rdy;
    ahb.hsel <= 1'h0;
    ahb.htrans <= 2'h0;
    ahb.hwdata <= d;
    rdy;
    rd = O_HRDATA;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    bus(1'h0, a, 32'h0);
    chk(e, rd & m);
  endtask
  task automatic pulse_pause;
    send <= 1'h1;
    cyc(1);
    send <= 1'h0;
    hi = 0;
    diff = 0;
    repeat (3 * PC)
    begin
      @(negedge I_CLK_SYS);
      hi += (O_REG_TX_HALT === 1'h1);
      diff += (O_REG_TX_HALT !== O_PRI_TX_HALT);
    end
    @(posedge I_CLK_SYS);
    chk(PC, hi);
    chk(0, diff);
  endtask
  // ****
  // main sequence
  // ****
  initial
  begin
    cyc(8);
    I_RST_B <= 1'h1;
    cyc(1);
    rdc(OFS_CTRL, 32'h1);
    rdc(OFS_THR_MAIN, 32'hc0);
    rdc(OFS_THR_BKP, 32'he0);
    rdc(OFS_IRQ_MASK, 32'h0);
    rdc(OFS_IRQ_STAT, 32'h0);
    rdc(8'h20, 32'h0);
    thr = 32'h20 + ($unsigned($random(seed)) & 32'h3f);
    bkp = thr + 32'h10;
    bus(1'h1, OFS_THR_MAIN, thr);
    bus(1'h1, OFS_THR_BKP, bkp);
    rdc(OFS_THR_MAIN, thr);
    rdc(OFS_THR_BKP, bkp);
    $display("test registers done");
    n0 = req_cnt;
    reg_fill <= thr[7:0] - 8'h1;
    pri_fill <= 8'($unsigned($random(seed)) % thr);
    cyc(20);
    chk(n0, req_cnt);
    pri_fill <= 8'h0;
    reg_fill <= thr[7:0];
    cyc(3);
    chk(n0 + 1, req_cnt);
    rdc(OFS_STATE, 32'h2, 32'hf);
    watch <= 1'h1;
    cyc(60);
    watch <= 1'h0;
    chk(0, gap_cnt);
    chk(1, req_cnt > n0 + 4);
    reg_fill <= 8'h0;
    cyc(3);
    rdc(OFS_IRQ_STAT, 32'h1);
    $display("test main pause done");
    cyc(PC);
    reg_fill <= thr[7:0];
    cyc(2);
    reg_fill <= bkp[7:0];
    cyc(2);
    reg_fill <= 8'h0;
    cyc(2);
    rdc(OFS_IRQ_STAT, 32'h3);
    rdc(OFS_IRQ_STAT, 32'h0);
    $display("test backup done");
    cyc(PC);
    n0 = req_cnt;
    pri_fill <= thr[7:0];
    cyc(3);
    chk(n0 + 1, req_cnt);
    rdc(OFS_STATE, 32'h4, 32'hf);
    pri_fill <= 8'h0;
    cyc(PC);
    bus(1'h1, OFS_CTRL, 32'h0);
    n0 = req_cnt;
    reg_fill <= thr[7:0];
    cyc(20);
    chk(n0, req_cnt);
    reg_fill <= 8'h0;
    bus(1'h1, OFS_CTRL, 32'h1);
    $display("test trigger ports done");
    bus(1'h1, OFS_IRQ_MASK, 32'h4);
    rdc(OFS_IRQ_STAT, 32'h1);
    pulse_pause;
    chk(1'h1, O_IRQ);
    rdc(OFS_IRQ_STAT, 32'h4);
    chk(1'h0, O_IRQ);
    bus(1'h1, OFS_IRQ_MASK, 32'h0);
    pulse_pause;
    chk(1'h0, O_IRQ);
    rdc(OFS_IRQ_STAT, 32'h4);
    $display("test pause receive done");
    reg_ovfl <= 1'h1;
    cyc(1);
    reg_ovfl <= 1'h0;
    pri_ovfl <= 1'h1;
    cyc(1);
    pri_ovfl <= 1'h0;
    cyc(2);
    rdc(OFS_IRQ_STAT, 32'h8);
    chk(1'h0, restart_seen);
    chk(2, nofc_rst_cnt);
    chk(1'h0, nofc_act);
    I_RST_B <= 1'h0;
    cyc(2);
    I_RST_B <= 1'h1;
    cyc(1);
    rdc(OFS_THR_MAIN, 32'hc0);
    $display("test overflow and reset done");
    end_of_test;
  end
endmodule
